// *** rtl/ccf_pkg.sv ***
// shared constants and types of the cpu cycle, flag and interrupt gate core
package ccf_pkg;
	localparam int SYNC_STAGES = 3;
	localparam logic [3:0] ACC_RST = 4'h0;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [3:0] PORT_RST = 4'h0;
	localparam logic [3:0] CAP_IDLE = 4'hF;
	localparam int FLG_CARRY = 0;
	localparam int FLG_ZERO = 1;
	localparam int FLG_WRAP = 2;
	localparam int GATE_ENABLE = 0;
	localparam logic [2:0] GATE_UNUSED = 3'h7;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [1:0] CYC_NONE = 2'h0;

	typedef enum logic [3:0] {
		OPC_NOP,
		OPC_LOAD,
		OPC_ADD,
		OPC_SUB,
		OPC_SWAP,
		OPC_PORT_OUT,
		OPC_PORT_IN,
		OPC_PUSH_ONE,
		OPC_POP_ONE,
		OPC_UNMASK_ALL,
		OPC_MASK_ALL,
		OPC_RETURN
	} ccf_opc_t;

	typedef struct packed {
		ccf_opc_t opc;
		logic [3:0] data;
	} ccf_op_t;

	typedef struct packed {
		logic [3:0] flags;
		logic [3:0] acc;
	} ccf_frame_t;

	typedef enum logic {ST_FIRST, ST_SECOND} ccf_state_t;
endpackage

// *** rtl/ccf_core.sv ***
// machine cycle timing, accumulator, flags and interrupt gate of the 4-bit cpu
// Notes on behaviour
// - a machine cycle is two states, each falling clock edge to falling edge
// - every instruction takes one to three whole machine cycles by its class
// - crystal source is halved for the system clock, rc source used undivided
// - port write drives the pin at the rising clock edge of the second state
// - port read samples in first state high half, to accumulator next cycle
// - input capture is low dominant: any low gives 0, only steady high gives 1
// - interrupt sources sampled at falling edge, pending latch set early first state
// - an accepted interrupt starts its routine in the very next machine cycle
// - reset clears the accumulator
// - push of pointer pair one saves accumulator and flags, pop restores them with the rc source only; a crystal pop reads an expired frame
// - carry takes add carry or subtract borrow, cleared at reset
// - loading the accumulator sets zero flag on zero value, clears it otherwise
// - the swap instruction leaves the zero flag alone
// - wrap flag set on pointer pair or table address overflow, reset clear
// - gate bit 0 enables interrupts; when low only the watchdog gets through
// - accepting an interrupt clears the enable, the return op sets it again
// - reset clears the global interrupt enable
// - the four-bit gate register reads through data memory, cannot be written
// - only the unmask, mask and return ops change the enable from software
`timescale 1ns/1ns
module ccf_core #(
	parameter int NSRC = 4
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic osc_is_crystal,
	input wire logic [3:0] port_pin_in,
	output logic [3:0] port_pin_out,
	input wire logic [NSRC-1:0] irq_src,
	input wire logic wdt_irq,
	input wire logic op_valid,
	input wire ccf_pkg::ccf_op_t op_in,
	output logic op_ready,
	input wire logic [2:0] ptr_wrap,
	input wire ccf_pkg::ccf_frame_t stk_rdata,
	output logic stk_push,
	output logic stk_pop,
	output ccf_pkg::ccf_frame_t stk_wdata,
	output logic irq_take,
	output logic [$clog2(NSRC+1)-1:0] irq_id,
	output logic [3:0] acc,
	output logic [3:0] flags,
	output logic [3:0] gate_rd,
	output logic [3:0] swap_out,
	output logic clk_cpu,
	output logic state_second,
	output logic mc_start
);
	import ccf_pkg::*;

	localparam int PW = 4 + NSRC + 1;
	localparam int IW = $clog2(NSRC + 1);

	function automatic logic [1:0] op_cycles(input ccf_opc_t o);
		unique case (o)
			OPC_POP_ONE: op_cycles = CYC_TWO;
			OPC_RETURN: op_cycles = CYC_THREE;
			default: op_cycles = CYC_ONE;
		endcase
	endfunction

	function automatic logic is_zero(input logic [3:0] v);
		is_zero = (v == 4'h0);
	endfunction

	// pin synchronisers, strap included
	logic [PW-1:0] s1_ff, s2_ff, s3_ff, pin_ok_ff, nxt_pin_ok;
	logic [2:0] xs_ff;
	logic xtal_ff, nxt_xtal;
	logic [PW-1:0] pin_raw;
	logic [3:0] pin_in_ok;
	logic [NSRC:0] src_ok;

	assign pin_raw = {wdt_irq, irq_src, port_pin_in};
	assign pin_in_ok = pin_ok_ff[3:0];
	assign src_ok = pin_ok_ff[PW-1:4];

	always_comb begin
		nxt_pin_ok = pin_ok_ff;
		for (int i = 0; i < PW; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_pin_ok[i] = s3_ff[i];
			end
		end
		nxt_xtal = xtal_ff;
		if (xs_ff[1] == xs_ff[2]) begin
			nxt_xtal = xs_ff[2];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			pin_ok_ff <= '0;
			xs_ff <= 3'h0;
			xtal_ff <= 1'b0;
		end else begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			pin_ok_ff <= nxt_pin_ok;
			xs_ff <= {xs_ff[1:0], osc_is_crystal};
			xtal_ff <= nxt_xtal;
		end
	end

	// system clock as enables: half_en marks each cpu clock half period
	logic div_ff, nxt_div, lvl_ff, nxt_lvl;
	ccf_state_t st_ff, nxt_st;
	logic half_en, fall, rise;

	assign half_en = xtal_ff ? div_ff : 1'b1;
	assign fall = half_en && lvl_ff;
	assign rise = half_en && !lvl_ff;
	assign mc_start = fall && (st_ff == ST_SECOND);
	assign clk_cpu = lvl_ff;
	assign state_second = (st_ff == ST_SECOND);

	always_comb begin
		nxt_div = ~div_ff;
		nxt_lvl = half_en ? ~lvl_ff : lvl_ff;
		nxt_st = st_ff;
		if (fall) begin
			nxt_st = (st_ff == ST_FIRST) ? ST_SECOND : ST_FIRST;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_ff <= 1'b0;
			lvl_ff <= 1'b0;
			st_ff <= ST_SECOND;
		end else begin
			div_ff <= nxt_div;
			lvl_ff <= nxt_lvl;
			st_ff <= nxt_st;
		end
	end

	// core state
	ccf_opc_t cur_ff, nxt_cur;
	logic [1:0] left_ff, nxt_left;
	logic [3:0] acc_ff, nxt_acc, flg_ff, nxt_flg, cap_ff, nxt_cap;
	logic [3:0] port_ff, nxt_port, swp_ff, nxt_swp;
	logic [NSRC:0] pend_ff, nxt_pend, pick;
	logic gie_ff, nxt_gie, take_ff, nxt_take, push_ff, nxt_push, pop_ff, nxt_pop;
	logic [IW-1:0] id_ff, nxt_id;
	ccf_frame_t wd_ff, nxt_wd;
	logic finish, free, irq_ok;
	logic [4:0] sum;

	// watchdog sits at the top index and ignores the enable
	always_comb begin
		pick = pend_ff;
		if (!gie_ff) begin
			pick[NSRC-1:0] = '0;
		end
	end

	assign finish = mc_start && (left_ff == CYC_ONE);
	assign free = left_ff <= CYC_ONE;
	assign irq_ok = |pick;
	assign op_ready = mc_start && free && !irq_ok;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_left = left_ff;
		nxt_acc = acc_ff;
		nxt_flg = flg_ff;
		nxt_cap = cap_ff;
		nxt_port = port_ff;
		nxt_swp = swp_ff;
		nxt_pend = pend_ff;
		nxt_gie = gie_ff;
		nxt_take = 1'b0;
		nxt_push = 1'b0;
		nxt_pop = 1'b0;
		nxt_id = id_ff;
		nxt_wd = wd_ff;
		sum = 5'h00;
		// capture window is the whole high half of the first state
		if (rise && st_ff == ST_FIRST) begin
			nxt_cap = CAP_IDLE;
		end else if (lvl_ff && st_ff == ST_FIRST) begin
			nxt_cap = cap_ff & pin_in_ok;
		end
		if (rise && st_ff == ST_SECOND && left_ff != CYC_NONE && cur_ff == OPC_PORT_OUT) begin
			nxt_port = acc_ff;
		end
		if (finish) begin
			unique case (cur_ff)
				OPC_LOAD: begin
					nxt_acc = swp_ff;
					nxt_flg[FLG_ZERO] = is_zero(swp_ff);
				end
				OPC_ADD: begin
					sum = {1'b0, acc_ff} + {1'b0, swp_ff};
					nxt_acc = sum[3:0];
					nxt_flg[FLG_CARRY] = sum[4];
					nxt_flg[FLG_ZERO] = is_zero(sum[3:0]);
				end
				OPC_SUB: begin
					sum = {1'b0, acc_ff} - {1'b0, swp_ff};
					nxt_acc = sum[3:0];
					nxt_flg[FLG_CARRY] = sum[4];
					nxt_flg[FLG_ZERO] = is_zero(sum[3:0]);
				end
				OPC_SWAP: begin
					nxt_acc = swp_ff;
					nxt_swp = acc_ff;
				end
				OPC_PORT_IN: begin
					nxt_acc = cap_ff;
					nxt_flg[FLG_ZERO] = is_zero(cap_ff);
				end
				OPC_PUSH_ONE: begin
					nxt_push = 1'b1;
					nxt_wd = '{flags: flg_ff, acc: acc_ff};
				end
				OPC_POP_ONE: begin
					nxt_acc = stk_rdata.acc;
					nxt_flg = stk_rdata.flags;
				end
				OPC_UNMASK_ALL: nxt_gie = 1'b1;
				OPC_MASK_ALL: nxt_gie = 1'b0;
				OPC_RETURN: nxt_gie = 1'b1;
				default: nxt_gie = gie_ff;
			endcase
		end
		// wrap is sticky; pointer overflow wins over a flag restore
		if (|ptr_wrap) begin
			nxt_flg[FLG_WRAP] = 1'b1;
		end
		if (mc_start) begin
			if (free) begin
				nxt_left = CYC_NONE;
				nxt_cur = OPC_NOP;
				if (irq_ok) begin
					nxt_gie = 1'b0;
					nxt_take = 1'b1;
					for (int i = NSRC; i >= 0; i--) begin
						if (pick[i]) begin
							nxt_id = IW'(i);
						end
					end
					nxt_pend = pend_ff & ~(pick & ~(pick - 1'b1));
				end else if (op_valid) begin
					nxt_cur = op_in.opc;
					nxt_left = op_cycles(op_in.opc);
					if (op_in.opc == OPC_SWAP || op_in.opc == OPC_LOAD ||
						op_in.opc == OPC_ADD || op_in.opc == OPC_SUB) begin
						nxt_swp = op_in.data;
					end
					nxt_pop = (op_in.opc == OPC_POP_ONE);
				end
			end else begin
				nxt_left = left_ff - CYC_ONE;
			end
			// sampled at the falling edge opening the first state; set beats ack
			nxt_pend = nxt_pend | src_ok;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cur_ff <= OPC_NOP;
			left_ff <= CYC_NONE;
			acc_ff <= ACC_RST;
			flg_ff <= FLAGS_RST;
			cap_ff <= CAP_IDLE;
			port_ff <= PORT_RST;
			swp_ff <= 4'h0;
			pend_ff <= '0;
			gie_ff <= 1'b0;
			take_ff <= 1'b0;
			push_ff <= 1'b0;
			pop_ff <= 1'b0;
			id_ff <= '0;
			wd_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
			left_ff <= nxt_left;
			acc_ff <= nxt_acc;
			flg_ff <= nxt_flg;
			cap_ff <= nxt_cap;
			port_ff <= nxt_port;
			swp_ff <= nxt_swp;
			pend_ff <= nxt_pend;
			gie_ff <= nxt_gie;
			take_ff <= nxt_take;
			push_ff <= nxt_push;
			pop_ff <= nxt_pop;
			id_ff <= nxt_id;
			wd_ff <= nxt_wd;
		end
	end

	assign port_pin_out = port_ff;
	assign acc = acc_ff;
	assign flags = flg_ff;
	// no write path exists into the gate register
	assign gate_rd = {GATE_UNUSED, gie_ff};
	assign swap_out = swp_ff;
	assign irq_take = take_ff;
	assign irq_id = id_ff;
	assign stk_push = push_ff;
	assign stk_pop = pop_ff;
	assign stk_wdata = wd_ff;

	sequence s_second_rise;
		rise && st_ff == ST_SECOND;
	endsequence

	sequence s_in_done;
		finish && cur_ff == OPC_PORT_IN;
	endsequence

	a_state_flip: assert property (@(posedge clk_sys) disable iff (!nrst)
		fall |=> st_ff != $past(st_ff))
		else $error("state did not flip at falling edge");

	a_xtal_halved: assert property (@(posedge clk_sys) disable iff (!nrst)
		xtal_ff && half_en && $stable(xtal_ff) |=> !half_en)
		else $error("crystal clock not halved");

	a_rc_undivided: assert property (@(posedge clk_sys) disable iff (!nrst)
		!xtal_ff |-> half_en)
		else $error("rc clock divided");

	a_port_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		$changed(port_pin_out) |-> $past(rise && st_ff == ST_SECOND))
		else $error("port changed outside second state rising edge");

	a_cap_low_dom: assert property (@(posedge clk_sys) disable iff (!nrst)
		lvl_ff && st_ff == ST_FIRST && !rise |=> (cap_ff & ~$past(pin_in_ok)) == 4'h0)
		else $error("low input not captured as zero");

	a_in_to_acc: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_in_done |=> acc == $past(cap_ff) && flags[FLG_ZERO] == (acc == 4'h0))
		else $error("port input not moved to accumulator");

	a_swap_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
		finish && cur_ff == OPC_SWAP && ptr_wrap == 3'h0 |=> $stable(flags))
		else $error("swap changed flags");

	a_take_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
		irq_take && irq_id != IW'(NSRC) |-> $past(gie_ff))
		else $error("masked interrupt taken");

	a_take_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		irq_take |-> !gie_ff && $past(mc_start))
		else $error("enable not cleared on acceptance");

	a_pend_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		mc_start && src_ok[0] |=> pend_ff[0] || irq_take)
		else $error("pending latch not set");

	a_out_timing: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_second_rise ##0 (left_ff != CYC_NONE && cur_ff == OPC_PORT_OUT)
		|=> port_pin_out == $past(acc))
		else $error("port write value wrong");

	a_cycle_count: assert property (@(posedge clk_sys) disable iff (!nrst)
		mc_start && op_ready && op_valid |=> left_ff >= CYC_ONE && left_ff <= CYC_THREE)
		else $error("instruction cycle count out of range");
endmodule

// *** bench/ccf_partner.sv ***
// register stack and port pin model facing the core
`timescale 1ns/1ns
module ccf_partner (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [3:0] pin_lvl,
	output logic [3:0] port_pin_in,
	input wire logic stk_push,
	input wire logic stk_pop,
	input wire ccf_pkg::ccf_frame_t stk_wdata,
	output ccf_pkg::ccf_frame_t stk_rdata
);
	import ccf_pkg::*;
	ccf_frame_t mem_ff [16];
	logic [3:0] sp_ff;
	logic [3:0] hold_ff;
	assign port_pin_in = pin_lvl;
	// frame valid only a short while after the pop; junk after so late reads show
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sp_ff <= 4'h0;
			hold_ff <= 4'h0;
			stk_rdata <= '0;
		end else if (stk_push) begin
			mem_ff[sp_ff] <= stk_wdata;
			sp_ff <= sp_ff + 4'h1;
		end else if (stk_pop) begin
			stk_rdata <= mem_ff[sp_ff - 4'h1];
			sp_ff <= sp_ff - 4'h1;
			hold_ff <= 4'h9;
		end else if (hold_ff != 4'h0) begin
			hold_ff <= hold_ff - 4'h1;
		end else begin
			stk_rdata <= ~stk_rdata;
		end
	end
endmodule

// *** bench/tb_top.sv ***
// bench for the cycle, flag and gate core against an integer model
`timescale 1ns/1ns
module tb_top;
	import ccf_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic osc_is_crystal = 1'b0;
	logic [3:0] pin_lvl = 4'h0;
	logic [3:0] irq_src = 4'h0;
	logic wdt_irq = 1'b0;
	logic op_valid = 1'b0;
	ccf_op_t op_in = '0;
	logic [2:0] ptr_wrap = 3'h0;
	logic [3:0] port_pin_in, port_pin_out, acc, flags, gate_rd, swap_out;
	logic op_ready, stk_push, stk_pop, irq_take, clk_cpu, state_second, mc_start;
	logic [2:0] irq_id, last_id;
	ccf_frame_t stk_rdata, stk_wdata;
	int n_mismatch = 0;
	int compares = 0;
	int n_take = 0;
	int m_acc, m_c, m_z, m_w, m_en;
	int stk_q[$];
	always #10 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		if (irq_take === 1'b1) begin
			n_take++;
			last_id = irq_id;
		end
	end
	ccf_core u_ccf_core (
		.clk_sys(clk_sys), .nrst(nrst), .osc_is_crystal(osc_is_crystal),
		.port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .irq_src(irq_src),
		.wdt_irq(wdt_irq), .op_valid(op_valid), .op_in(op_in), .op_ready(op_ready),
		.ptr_wrap(ptr_wrap), .stk_rdata(stk_rdata), .stk_push(stk_push), .stk_pop(stk_pop),
		.stk_wdata(stk_wdata), .irq_take(irq_take), .irq_id(irq_id), .acc(acc),
		.flags(flags), .gate_rd(gate_rd), .swap_out(swap_out), .clk_cpu(clk_cpu),
		.state_second(state_second), .mc_start(mc_start)
	);
	ccf_partner u_ccf_partner (
		.clk_sys(clk_sys), .nrst(nrst), .pin_lvl(pin_lvl), .port_pin_in(port_pin_in),
		.stk_push(stk_push), .stk_pop(stk_pop), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata)
	);
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk_v(input string nm, input logic [3:0] e, input logic [3:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_n(input string nm, input int e, input int g);
		compares++;
		if (g != e) begin
			n_mismatch++;
			$display("mismatch %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	function automatic logic [3:0] fl();
		return {1'b0, m_w[0], m_z[0], m_c[0]};
	endfunction
	task automatic chk_all();
		@(negedge clk_sys);
		chk_v("acc", 4'(m_acc), acc);
		chk_v("flags", fl(), flags);
		chk_v("gate", {3'h7, m_en[0]}, gate_rd);
	endtask
	task automatic do_reset();
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		m_acc = 0;
		m_c = 0;
		m_z = 0;
		m_w = 0;
		m_en = 0;
		stk_q.delete();
		chk_all();
		chk_v("pins", 4'h0, port_pin_out);
	endtask
	// counts clk_sys cycles up to the next machine cycle start; sampled mid cycle
	task automatic wait_mc(output int k);
		logic hit;
		k = 0;
		hit = 1'b0;
		while (!hit && k < 40) begin
			@(negedge clk_sys);
			k++;
			hit = (mc_start === 1'b1);
			if (hit) chk_v("phase", 4'h3, {2'b00, clk_cpu, state_second});
			@(posedge clk_sys);
		end
	endtask
	task automatic do_op(input ccf_opc_t o, input logic [3:0] d, input int nc);
		int k;
		logic hit;
		@(posedge clk_sys);
		op_valid <= 1'b1;
		op_in <= '{opc: o, data: d};
		k = 0;
		hit = 1'b0;
		// ready looked at mid cycle, the op is taken at the following rising edge
		while (!hit && k < 100) begin
			@(negedge clk_sys);
			k++;
			hit = (op_ready === 1'b1);
			@(posedge clk_sys);
		end
		op_valid <= 1'b0;
		chk_n("op taken", 1, int'(hit));
		repeat (nc) wait_mc(k);
		@(posedge clk_sys);
	endtask
	task automatic run(input ccf_opc_t o, input logic [3:0] d);
		int s;
		int old;
		old = m_acc;
		s = m_acc + 16 * fl();
		case (o)
			OPC_LOAD, OPC_PORT_IN, OPC_SWAP: m_acc = d;
			OPC_ADD: m_acc = m_acc + d;
			OPC_SUB: m_acc = m_acc - d;
			OPC_PUSH_ONE: stk_q.push_back(s);
			OPC_POP_ONE: s = stk_q.pop_back();
			OPC_UNMASK_ALL, OPC_RETURN: m_en = 1;
			OPC_MASK_ALL: m_en = 0;
			default: ;
		endcase
		if (o == OPC_ADD) m_c = m_acc > 15;
		if (o == OPC_SUB) m_c = m_acc < 0;
		m_acc = m_acc & 15;
		if (o inside {OPC_LOAD, OPC_PORT_IN, OPC_ADD, OPC_SUB}) m_z = m_acc == 0;
		if (o == OPC_POP_ONE) begin
			m_acc = s & 15;
			m_c = s >> 4 & 1;
			m_z = s >> 5 & 1;
			m_w = s >> 6 & 1;
		end
		do_op(o, d, o == OPC_POP_ONE ? 2 : o == OPC_RETURN ? 3 : 1);
		chk_all();
		if (o == OPC_SWAP) chk_v("swap", 4'(old), swap_out);
		if (o == OPC_PORT_OUT) chk_v("pins", 4'(m_acc), port_pin_out);
	endtask
	// short pulse so exactly one machine cycle start latches it
	task automatic irq_try(input int idx, input int exp);
		int n0;
		n0 = n_take;
		@(posedge clk_sys);
		irq_src <= 4'(idx < 4 ? 1 << idx : 0);
		wdt_irq <= (idx == 4);
		repeat (4) @(posedge clk_sys);
		irq_src <= 4'h0;
		wdt_irq <= 1'b0;
		repeat (24) @(posedge clk_sys);
		if (exp == 1) m_en = 0;
		chk_n("takes", exp, n_take - n0);
		if (exp == 1) chk_v("irq id", 4'(idx), {1'b0, last_id});
		chk_all();
	endtask
	initial begin
		int k;
		ccf_opc_t o;
		void'($urandom(32'h0000_bb4b));
		do_reset();
		wait_mc(k);
		wait_mc(k);
		chk_n("mc period", 4, k);
		run(OPC_LOAD, 4'hF);
		run(OPC_ADD, 4'h1);
		run(OPC_SUB, 4'h1);
		run(OPC_SWAP, 4'h0);
		for (int i = 0; i < 24; i++) begin
			o = ccf_opc_t'(1 + $urandom % 4);
			run(o, 4'($urandom));
			if (i % 6 == 5) begin
				@(posedge clk_sys);
				pin_lvl <= 4'($urandom);
				repeat (5) @(posedge clk_sys);
				run(OPC_PORT_IN, pin_lvl);
				run(OPC_PORT_OUT, 4'h0);
			end
		end
		for (int i = 0; i < 3; i++) begin
			run(OPC_PUSH_ONE, 4'h0);
			@(posedge clk_sys);
			ptr_wrap <= 3'(1 << i);
			@(posedge clk_sys);
			ptr_wrap <= 3'h0;
			@(posedge clk_sys);
			m_w = 1;
			chk_all();
			run(OPC_LOAD, 4'(i));
			run(OPC_POP_ONE, 4'h0);
		end
		do_reset();
		run(OPC_UNMASK_ALL, 4'h0);
		irq_try(2, 1);
		run(OPC_RETURN, 4'h0);
		run(OPC_MASK_ALL, 4'h0);
		irq_try(0, 0);
		irq_try(4, 1);
		@(posedge clk_sys);
		osc_is_crystal <= 1'b1;
		repeat (20) @(posedge clk_sys);
		wait_mc(k);
		wait_mc(k);
		chk_n("mc period", 8, k);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		end_sim();
	end
endmodule
